// ===== src/clock_fail_watchdog_lowpower.sv
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ps
module clock_fail_watchdog_lowpower
   import cfw_pkg::*;
#(
   parameter int OSC_DIV = OSC_DIV_DEFAULT,
   parameter int MISS_CYCLES = MISS_CYCLES_DEFAULT
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire bus_req_type bus,
   output logic [31:0] rdata,
   input wire logic input_clock_in,
   input wire logic [31:0] gpio_a_n,
   input wire logic external_reset_n,
   input wire logic debug_wake_n,
   input wire logic debug_reset,
   input wire logic cpu_irq_pending,
   output logic limp_clock_sel,
   output logic nmi_out,
   output logic watchdog_reset_out_n,
   output logic watchdog_interrupt_out_n,
   output logic device_reset_n,
   output logic cpu_clock_en,
   output logic sys_clock_en,
   output logic osc_enable,
   output logic pll_enable,
   output logic pin_hold,
   output logic jtag_clock_en,
   output logic wake_event
);
   initial begin
      if (OSC_DIV < 2 || OSC_DIV > 255 || MISS_CYCLES < 4 || MISS_CYCLES > 65535) begin
         $error("unsupported parameter value");
      end
   end

   // ----------------------------------------
   // reset release and input synchronisers
   // ----------------------------------------
   logic [1:0] rst_pipe_reg;
   logic rst_n;
   logic [2:0] cpu_clock_sync_reg;
   logic [2:0] xrs_sync_reg;
   logic [2:0] dbg_sync_reg;
   logic [31:0] gpio_s1_reg, gpio_s2_reg, gpio_s3_reg;

   // release the reset through two flops, then sample the pins three deep
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rst_pipe_reg <= 2'b00;
      end else begin
         rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_pipe_reg[1];

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cpu_clock_sync_reg <= 3'b000;
         xrs_sync_reg <= 3'b111;
         dbg_sync_reg <= 3'b111;
         gpio_s1_reg <= 32'hFFFF_FFFF;
         gpio_s2_reg <= 32'hFFFF_FFFF;
         gpio_s3_reg <= 32'hFFFF_FFFF;
      end else begin
         cpu_clock_sync_reg <= {cpu_clock_sync_reg[1:0], input_clock_in};
         xrs_sync_reg <= {xrs_sync_reg[1:0], external_reset_n};
         dbg_sync_reg <= {dbg_sync_reg[1:0], debug_wake_n};
         gpio_s1_reg <= gpio_a_n;
         gpio_s2_reg <= gpio_s1_reg;
         gpio_s3_reg <= gpio_s2_reg;
      end
   end

   // a level counts only once stages two and three agree
   function automatic logic agreed_low(input logic s2, input logic s3);
      agreed_low = !s2 && !s3;
   endfunction : agreed_low

   logic ext_reset_low, dbg_low;
   logic [31:0] pin_low;
   assign ext_reset_low = agreed_low(xrs_sync_reg[1], xrs_sync_reg[2]);
   assign dbg_low = agreed_low(dbg_sync_reg[1], dbg_sync_reg[2]);
   genvar gi;
   generate
      for (gi = 0; gi < 32; gi++) begin : g_pin
         assign pin_low[gi] = agreed_low(gpio_s2_reg[gi], gpio_s3_reg[gi]);
      end
   endgenerate

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [7:0] osc_div_reg, osc_div_next;
   logic osc_tick;
   logic cpu_clock_level_reg, cpu_clock_level_next;
   logic [15:0] miss_cnt_reg, miss_cnt_next;
   logic limp_reg, limp_next;
   logic missing_reg, missing_next;
   logic nmi_reg, nmi_next;
   logic [15:0] nmi_cnt_reg, nmi_cnt_next;
   logic [15:0] ctrl_reg, ctrl_next;
   logic [31:0] wake_sel_reg, wake_sel_next;
   logic [15:0] nmi_period_reg, nmi_period_next;
   logic [3:0] pll_mul_reg, pll_mul_next;
   logic [1:0] pll_sts_reg, pll_sts_next;
   logic key_armed_reg, key_armed_next;
   logic [7:0] wd_cnt_reg, wd_cnt_next;
   logic [9:0] wd_pulse_reg, wd_pulse_next;
   logic wd_pulse_irq_reg, wd_pulse_irq_next;
   logic [QUAL_W-1:0] qual_cnt_reg, qual_cnt_next;
   lp_state_type lp_state_reg, lp_state_next;
   logic [3:0] dev_rst_cnt_reg, dev_rst_cnt_next;
   logic pll_clear_reg, pll_clear_next;
   logic [31:0] rdata_reg, rdata_next;
   logic wake_event_reg, wake_event_next;
   logic lost_now, key_clear, wd_start, wd_irq_active, wd_clk_active;
   logic pin_wake, qual_done, any_reset, ext_or_wd_reset;

   // oscillator rate as an enable pulse; keeps running in halt since the
   // watchdog lives on the internal oscillator there
   assign osc_tick = (osc_div_reg == 8'(OSC_DIV - 1));
   assign wd_clk_active = !ctrl_reg[CTRL_WD_DIS];
   assign lost_now = (miss_cnt_reg == 16'(MISS_CYCLES - 1));
   assign key_clear = bus.wr && (bus.addr == OFF_KEY) && key_armed_reg
      && (bus.wdata[7:0] == KEY_SECOND);
   assign wd_start = osc_tick && wd_clk_active && !limp_reg && (wd_pulse_reg == 10'h000)
      && (wd_cnt_reg == WD_MAX);
   assign wd_irq_active = (wd_pulse_reg != 10'h000) && wd_pulse_irq_reg;
   assign pin_wake = |(pin_low & wake_sel_reg);
   assign qual_done = (qual_cnt_reg == ctrl_reg[CTRL_QUAL_LSB +: QUAL_W]);
   // halt wakes by device reset when the watchdog fires
   assign ext_or_wd_reset = ext_reset_low || (wd_start && !ctrl_reg[CTRL_WD_IRQ]);
   assign any_reset = ext_or_wd_reset || debug_reset
      || (lost_now && !limp_reg && !ctrl_reg[CTRL_POLICY])
      || (nmi_reg && ctrl_reg[CTRL_POLICY] && nmi_cnt_reg == nmi_period_reg)
      || (lp_state_reg == LP_HALT && wd_start);

   // ----------------------------------------
   // next-state logic
   // ----------------------------------------
   always_comb begin
      osc_div_next = osc_tick ? 8'h00 : osc_div_reg + 8'h01;
      cpu_clock_level_next = cpu_clock_level_reg;
      miss_cnt_next = miss_cnt_reg;
      limp_next = limp_reg;
      missing_next = missing_reg;
      nmi_next = nmi_reg;
      nmi_cnt_next = nmi_cnt_reg;
      ctrl_next = ctrl_reg;
      wake_sel_next = wake_sel_reg;
      nmi_period_next = nmi_period_reg;
      pll_mul_next = pll_mul_reg;
      pll_sts_next = pll_sts_reg;
      key_armed_next = key_armed_reg;
      wd_cnt_next = wd_cnt_reg;
      wd_pulse_next = wd_pulse_reg;
      wd_pulse_irq_next = wd_pulse_irq_reg;
      qual_cnt_next = qual_cnt_reg;
      lp_state_next = lp_state_reg;
      dev_rst_cnt_next = (dev_rst_cnt_reg != 4'h0) ? dev_rst_cnt_reg - 4'h1 : 4'h0;
      pll_clear_next = 1'b0;
      rdata_next = 32'h0000_0000;
      wake_event_next = 1'b0;

      // input clock watch: a settled level change restarts the gap count
      if (cpu_clock_sync_reg[1] == cpu_clock_sync_reg[2] && cpu_clock_sync_reg[2] != cpu_clock_level_reg) begin
         cpu_clock_level_next = cpu_clock_sync_reg[2];
         miss_cnt_next = 16'h0000;
      end else if (!lost_now) begin
         miss_cnt_next = miss_cnt_reg + 16'h0001;
      end
      if (lost_now) begin
         limp_next = 1'b1;
      end else if (!missing_reg) begin
         limp_next = 1'b0;
      end

      // nmi watchdog counts only while the nmi waits for service
      if (nmi_reg && ctrl_reg[CTRL_POLICY]) begin
         nmi_cnt_next = nmi_cnt_reg + 16'h0001;
      end else begin
         nmi_cnt_next = 16'h0000;
      end

      // cpu watchdog counter and output pulse
      if (wd_pulse_reg != 10'h000 && osc_tick) begin
         wd_pulse_next = wd_pulse_reg - 10'h001;
      end
      if (wd_start) begin
         wd_pulse_next = WD_PULSE_TICKS;
         wd_pulse_irq_next = ctrl_reg[CTRL_WD_IRQ];
         wd_cnt_next = 8'h00;
      end else if (osc_tick && wd_clk_active && !limp_reg && wd_pulse_reg == 10'h000) begin
         wd_cnt_next = wd_cnt_reg + 8'h01;
      end else if (!wd_clk_active) begin
         wd_cnt_next = 8'h00;
      end

      // register writes
      if (bus.wr) begin
         unique case (bus.addr)
            OFF_KEY: begin
               key_armed_next = (bus.wdata[7:0] == KEY_FIRST);
               if (key_clear) begin
                  wd_cnt_next = 8'h00;
               end
            end
            OFF_CTRL: ctrl_next = bus.wdata[15:0];
            OFF_STATUS: begin
               if (bus.wdata[ST_MISSING]) begin
                  missing_next = 1'b0;
               end
               if (bus.wdata[ST_NMI]) begin
                  nmi_next = 1'b0;
               end
            end
            OFF_WAKE_SEL: wake_sel_next = bus.wdata;
            OFF_NMI_PERIOD: nmi_period_next = bus.wdata[15:0];
            OFF_PLL_MUL: pll_mul_next = bus.wdata[3:0];
            OFF_PLL_STS: pll_sts_next = bus.wdata[1:0];
            OFF_LP_ENTER: begin
               // a write here stands for the idle instruction
               if (lp_state_reg == LP_RUN) begin
                  if (ctrl_reg[CTRL_MODE_LSB +: 2] == LPM_IDLE) begin
                     lp_state_next = LP_IDLE;
                  end else if (ctrl_reg[CTRL_MODE_LSB +: 2] == LPM_STANDBY) begin
                     lp_state_next = LP_STANDBY;
                  end else if (wd_clk_active) begin
                     lp_state_next = LP_HALT;
                  end
               end
            end
            default: ;
         endcase
      end
      // wake handling; qualification restarts whenever the pins release
      unique case (lp_state_reg)
         LP_RUN: qual_cnt_next = '0;
         LP_IDLE: begin
            if (wd_irq_active || cpu_irq_pending) begin
               lp_state_next = LP_RUN;
               wake_event_next = 1'b1;
            end
         end
         LP_STANDBY, LP_HALT: begin
            if (!pin_wake) begin
               qual_cnt_next = '0;
            end else if (osc_tick && !qual_done) begin
               qual_cnt_next = qual_cnt_reg + QUAL_W'(1);
            end
            if ((pin_wake && qual_done) || dbg_low
               || (lp_state_reg == LP_STANDBY && wd_irq_active && ctrl_reg[CTRL_WD_WAKE])) begin
               lp_state_next = LP_RUN;
               wake_event_next = 1'b1;
            end
         end
         default: lp_state_next = LP_RUN;
      endcase

      if (bus.rd) begin
         unique case (bus.addr)
            OFF_CTRL: rdata_next = {16'h0000, ctrl_reg};
            OFF_STATUS: rdata_next = {16'h0000, wd_cnt_reg, 5'h00, limp_reg, nmi_reg, missing_reg};
            OFF_WAKE_SEL: rdata_next = wake_sel_reg;
            OFF_NMI_PERIOD: rdata_next = {16'h0000, nmi_period_reg};
            OFF_PLL_MUL: rdata_next = {28'h000_0000, pll_mul_reg};
            OFF_PLL_STS: rdata_next = {30'h0000_0000, pll_sts_reg};
            default: rdata_next = 32'h0000_0000;
         endcase
      end

      // device reset: state, nmi, wd count, key and ctrl; the pll regs only ext/wd clear
      if (any_reset) begin
         dev_rst_cnt_next = DEV_RESET_CYCLES;
         lp_state_next = LP_RUN;
         nmi_next = 1'b0;
         wd_cnt_next = 8'h00;
         key_armed_next = 1'b0;
         ctrl_next = CTRL_RESET;
         pll_clear_next = ext_or_wd_reset;
      end
      // hardware sets win over software clears and over the reset they cause,
      // so an immediate clock-fail reset still leaves the nmi pending
      if (lost_now && !limp_reg) begin
         missing_next = 1'b1;
         nmi_next = 1'b1;
      end
      if (pll_clear_reg) begin
         pll_mul_next = PLL_MUL_RESET;
         pll_sts_next = PLL_STS_RESET;
      end
      if (ext_reset_low) begin
         missing_next = 1'b0;
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         osc_div_reg <= 8'h00;
         cpu_clock_level_reg <= 1'b0;
         miss_cnt_reg <= 16'h0000;
         limp_reg <= 1'b0;
         missing_reg <= 1'b0;
         nmi_reg <= 1'b0;
         nmi_cnt_reg <= 16'h0000;
         ctrl_reg <= CTRL_RESET;
         wake_sel_reg <= 32'h0000_0000;
         nmi_period_reg <= NMI_PERIOD_RESET;
         pll_mul_reg <= PLL_MUL_RESET;
         pll_sts_reg <= PLL_STS_RESET;
         key_armed_reg <= 1'b0;
         wd_cnt_reg <= 8'h00;
         wd_pulse_reg <= 10'h000;
         wd_pulse_irq_reg <= 1'b0;
         qual_cnt_reg <= '0;
         lp_state_reg <= LP_RUN;
         dev_rst_cnt_reg <= 4'h0;
         pll_clear_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         wake_event_reg <= 1'b0;
      end else begin
         osc_div_reg <= osc_div_next;
         cpu_clock_level_reg <= cpu_clock_level_next;
         miss_cnt_reg <= miss_cnt_next;
         limp_reg <= limp_next;
         missing_reg <= missing_next;
         nmi_reg <= nmi_next;
         nmi_cnt_reg <= nmi_cnt_next;
         ctrl_reg <= ctrl_next;
         wake_sel_reg <= wake_sel_next;
         nmi_period_reg <= nmi_period_next;
         pll_mul_reg <= pll_mul_next;
         pll_sts_reg <= pll_sts_next;
         key_armed_reg <= key_armed_next;
         wd_cnt_reg <= wd_cnt_next;
         wd_pulse_reg <= wd_pulse_next;
         wd_pulse_irq_reg <= wd_pulse_irq_next;
         qual_cnt_reg <= qual_cnt_next;
         lp_state_reg <= lp_state_next;
         dev_rst_cnt_reg <= dev_rst_cnt_next;
         pll_clear_reg <= pll_clear_next;
         rdata_reg <= rdata_next;
         wake_event_reg <= wake_event_next;
      end
   end

   // ----------------------------------------
   // outputs, all taken from flops
   // ----------------------------------------
   // outputs derive from next-state values, except limp, nmi and the pll multiplier term, which lag a cycle, and jtag, which is tied high
   logic [10:0] out_reg, out_next;
   always_comb begin
      out_next[0] = limp_reg;
      out_next[1] = nmi_reg;
      out_next[2] = !(wd_pulse_next != 10'h000 && !wd_pulse_irq_next);
      out_next[3] = !(wd_pulse_next != 10'h000 && wd_pulse_irq_next);
      out_next[4] = !(dev_rst_cnt_next != 4'h0);
      out_next[5] = (lp_state_next == LP_RUN) || (lp_state_next == LP_IDLE);
      out_next[6] = out_next[5];
      out_next[7] = (lp_state_next != LP_HALT);
      out_next[8] = out_next[7] && (pll_mul_reg != PLL_MUL_RESET);
      out_next[9] = (lp_state_next != LP_RUN);
      out_next[10] = 1'b1;
   end
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         out_reg <= 11'h4FC;
      end else begin
         out_reg <= out_next;
      end
   end
   assign {jtag_clock_en, pin_hold, pll_enable, osc_enable, sys_clock_en, cpu_clock_en,
      device_reset_n, watchdog_interrupt_out_n, watchdog_reset_out_n, nmi_out,
      limp_clock_sel} = out_reg;
   assign rdata = rdata_reg;
   assign wake_event = wake_event_reg;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   // wide enough for 512 ticks at the largest divider allowed
   logic [17:0] low_run_reg;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         low_run_reg <= 18'h0_0000;
      end else begin
         low_run_reg <= watchdog_reset_out_n ? 18'h0_0000 : low_run_reg + 18'h0_0001;
      end
   end

   sequence key_pair_s;
      bus.wr && bus.addr == OFF_KEY && bus.wdata[7:0] == KEY_FIRST
      ##1 bus.wr && bus.addr == OFF_KEY && bus.wdata[7:0] == KEY_SECOND;
   endsequence

   key_clear_a: assert property (key_pair_s |=> wd_cnt_reg == 8'h00)
      else $error("key pair did not clear watchdog");
   key_lone_a: assert property (bus.wr && bus.addr == OFF_KEY && !key_armed_reg && !osc_tick
      && !any_reset |=> $stable(wd_cnt_reg))
      else $error("lone key write changed watchdog");
   limp_hold_a: assert property (limp_reg && !key_clear && !any_reset |=> $stable(wd_cnt_reg))
      else $error("watchdog advanced in limp mode");
   wd_pulse_len_a: assert property ($rose(watchdog_reset_out_n) |->
      low_run_reg == 18'(512 * OSC_DIV))
      else $error("watchdog pulse length wrong");
   missing_set_a: assert property (lost_now && !limp_reg |=> missing_reg && nmi_reg ##1 nmi_out)
      else $error("clock loss not flagged");
   fail_reset_a: assert property (lost_now && !limp_reg && !ctrl_reg[CTRL_POLICY]
      |=> ##1 !device_reset_n)
      else $error("immediate clock fail reset missing");
   halt_entry_a: assert property (lp_state_reg == LP_HALT && $past(lp_state_reg) != LP_HALT
      |-> $past(wd_clk_active))
      else $error("halt entered without watchdog clock");
   hold_pins_a: assert property (lp_state_reg != LP_RUN |-> pin_hold)
      else $error("pins not held in low power");
   idle_clocks_a: assert property (lp_state_reg == LP_IDLE |=> cpu_clock_en && sys_clock_en)
      else $error("idle stopped clocks");
   standby_wake_a: assert property (lp_state_reg == LP_STANDBY && !any_reset && !dbg_low
      && !wd_irq_active && !(pin_wake && qual_done) |=> lp_state_reg == LP_STANDBY)
      else $error("standby left without qualified wake");
endmodule : clock_fail_watchdog_lowpower

// ===== include/cfw_pkg.sv
package cfw_pkg;
   // ----------------------------------------
   // register map (byte addresses)
   // ----------------------------------------
   localparam int ADDR_W = 5;
   localparam logic [4:0] OFF_KEY = 5'h00;
   localparam logic [4:0] OFF_CTRL = 5'h04;
   localparam logic [4:0] OFF_STATUS = 5'h08;
   localparam logic [4:0] OFF_WAKE_SEL = 5'h0C;
   localparam logic [4:0] OFF_NMI_PERIOD = 5'h10;
   localparam logic [4:0] OFF_PLL_MUL = 5'h14;
   localparam logic [4:0] OFF_PLL_STS = 5'h18;
   localparam logic [4:0] OFF_LP_ENTER = 5'h1C;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int CTRL_WD_DIS = 0;
   localparam int CTRL_WD_IRQ = 1;
   localparam int CTRL_POLICY = 2;
   localparam int CTRL_MODE_LSB = 3;
   localparam int CTRL_WD_WAKE = 5;
   localparam int CTRL_QUAL_LSB = 8;
   localparam int QUAL_W = 6;
   localparam int ST_MISSING = 0;
   localparam int ST_NMI = 1;
   localparam int ST_LIMP = 2;
   localparam int ST_WDCNT_LSB = 8;
   // ----------------------------------------
   // values, reset values and counts
   // ----------------------------------------
   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'hAA;
   localparam logic [7:0] WD_MAX = 8'hFF;
   localparam logic [1:0] LPM_IDLE = 2'h0;
   localparam logic [1:0] LPM_STANDBY = 2'h1;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] NMI_PERIOD_RESET = 16'h0800;
   localparam logic [3:0] PLL_MUL_RESET = 4'h0;
   localparam logic [1:0] PLL_STS_RESET = 2'h0;
   localparam logic [9:0] WD_PULSE_TICKS = 10'd512;
   localparam int OSC_DIV_DEFAULT = 4;
   localparam int MISS_CYCLES_DEFAULT = 64;
   localparam logic [3:0] DEV_RESET_CYCLES = 4'hF;
   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } bus_req_type;
   typedef enum logic [3:0] {
      LP_RUN = 4'b0001,
      LP_IDLE = 4'b0010,
      LP_STANDBY = 4'b0100,
      LP_HALT = 4'b1000
   } lp_state_type;
endpackage : cfw_pkg

// ===== test/osc_source_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// input clock source seen by the monitor
// ----------------------------------------
module osc_source_model (
   input wire logic clk_sys,
   input wire logic run,
   output logic clk_out
);
   logic [1:0] div_reg = 2'h0;
   // toggles every second cycle; a stopped source parks at its
   // last level like a dead crystal, so no edge reaches the monitor
   always @(posedge clk_sys) begin
      if (run) begin
         div_reg <= div_reg + 2'h1;
      end
   end
   assign clk_out = div_reg[1];
endmodule : osc_source_model

// ===== test/clock_fail_watchdog_lowpower_tb.sv
`timescale 1ns/1ps
module clock_fail_watchdog_lowpower_tb;
   import cfw_pkg::*;
   localparam int DIV = 2;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   bus_req_type bus = '0;
   logic [31:0] gpio_a_n = 32'hFFFF_FFFF;
   logic osc_run = 1'b1;
   logic [31:0] rdata, d, e;
   logic clk_in, limp, nmi, wdr_n, wdi_n, dev_n, cpu_en, sys_en, osc_en, pll_en;
   logic hold, jtag_en, wake;
   logic irq = 1'b0;
   logic dbg_rst = 1'b0;
   int bad_count = 0;
   int samples_checked = 0;
   int n;
   // ----------------------------------------
   // clock, parts
   // ----------------------------------------
   always #12.5 clk_sys = ~clk_sys;
   osc_source_model osc_source_model_i (.clk_sys(clk_sys), .run(osc_run), .clk_out(clk_in));
   clock_fail_watchdog_lowpower #(.OSC_DIV(DIV), .MISS_CYCLES(8))
   clock_fail_watchdog_lowpower_i (.clk_sys(clk_sys), .resetn(resetn), .bus(bus),
      .rdata(rdata), .input_clock_in(clk_in), .gpio_a_n(gpio_a_n),
      .external_reset_n(1'b1), .debug_wake_n(1'b1), .debug_reset(dbg_rst),
      .cpu_irq_pending(irq), .limp_clock_sel(limp), .nmi_out(nmi),
      .watchdog_reset_out_n(wdr_n), .watchdog_interrupt_out_n(wdi_n),
      .device_reset_n(dev_n), .cpu_clock_en(cpu_en), .sys_clock_en(sys_en),
      .osc_enable(osc_en), .pll_enable(pll_en), .pin_hold(hold),
      .jtag_clock_en(jtag_en), .wake_event(wake));
   // ----------------------------------------
   // bus cycles and compares
   // ----------------------------------------
   task automatic wr(input logic [4:0] a, input logic [31:0] v);
      @(posedge clk_sys);
      bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      bus <= '0;
   endtask : wr
   // back-to-back key pair, no idle cycle between the strobes
   task automatic key_pair();
      @(posedge clk_sys);
      bus <= '{addr: OFF_KEY, wdata: 32'h0000_0055, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      bus <= '{addr: OFF_KEY, wdata: 32'h0000_00AA, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      bus <= '0;
   endtask : key_pair
   task automatic rd(input logic [4:0] a, output logic [31:0] v);
      @(posedge clk_sys);
      bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      bus <= '0;
      #1 v = rdata;
   endtask : rd
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      samples_checked++;
      if (g !== x) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, x, g);
      end
   endtask : chk
   task automatic ok(input string nm, input logic c);
      chk(nm, 32'h0000_0001, {31'h0000_0000, c});
   endtask : ok
   // bounded wait; n returns the cycles spent
   task automatic wait_for(ref logic s, input logic lvl, input int lim, output int k);
      k = 0;
      while (s !== lvl && k < lim) begin
         @(posedge clk_sys);
         #1 k++;
      end
   endtask : wait_for
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : give_verdict
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_key();
      wr(OFF_KEY, 32'h0000_0055);
      wr(OFF_KEY, 32'h0000_00AA);
      repeat (80) @(posedge clk_sys);
      wr(OFF_KEY, 32'h0000_0055);
      wr(OFF_KEY, 32'h0000_0012);
      wr(OFF_KEY, 32'h0000_00AA);
      rd(OFF_STATUS, d);
      ok("cnt_kept", d[15:8] >= 8'h28);
      key_pair();
      rd(OFF_STATUS, d);
      ok("cnt_clr", d[15:8] <= 8'h04);
   endtask : t_key
   task automatic t_regs();
      rd(OFF_NMI_PERIOD, d);
      chk("nmi_period", 32'(NMI_PERIOD_RESET), d);
      rd(5'h1E, d);
      chk("unmapped", 32'h0000_0000, d);
      ok("jtag", jtag_en);
      // a debugger reset must leave the pll multiplier alone
      wr(OFF_PLL_MUL, 32'h0000_0005);
      dbg_rst <= 1'b1;
      @(posedge clk_sys);
      dbg_rst <= 1'b0;
      #1 ok("dbg_rst", !dev_n);
      repeat (16) @(posedge clk_sys);
      rd(OFF_PLL_MUL, d);
      chk("pll_kept", 32'h0000_0005, d);
   endtask : t_regs
   // watchdog in interrupt mode ends idle without a reset
   task automatic t_idle();
      wr(OFF_CTRL, 32'h0000_0002);
      wr(OFF_LP_ENTER, 32'h0000_0000);
      wait_for(hold, 1'b1, 4, n);
      ok("idle_hold", hold);
      ok("idle_clk", cpu_en & sys_en & osc_en);
      wait_for(wdi_n, 1'b0, 1200, n);
      ok("no_rst", wdr_n & dev_n);
      wait_for(wdi_n, 1'b1, 2000, n);
      chk("irq_len", 32'(512 * DIV), 32'(n));
      ok("idle_left", !hold);
      // a recognised cpu interrupt also ends idle, with a wake pulse
      wr(OFF_LP_ENTER, 32'h0000_0000);
      wait_for(hold, 1'b1, 4, n);
      irq <= 1'b1;
      wait_for(hold, 1'b0, 4, n);
      irq <= 1'b0;
      ok("irq_wake", !hold && wake);
   endtask : t_idle
   task automatic t_halt();
      wr(OFF_CTRL, 32'h0000_0011);
      wr(OFF_LP_ENTER, 32'h0000_0000);
      repeat (4) @(posedge clk_sys);
      ok("halt_refused", !hold);
      wr(OFF_PLL_MUL, 32'h0000_0005);
      wr(OFF_CTRL, 32'h0000_0010);
      key_pair();
      wr(OFF_LP_ENTER, 32'h0000_0000);
      wait_for(hold, 1'b1, 4, n);
      ok("halt_clk", !(osc_en | pll_en | cpu_en));
      ok("halt_jtag", jtag_en);
      wait_for(wdr_n, 1'b0, 1200, n);
      wait_for(wdr_n, 1'b1, 2000, n);
      chk("rst_len", 32'(512 * DIV), 32'(n));
      ok("halt_left", !hold);
      rd(OFF_PLL_MUL, d);
      chk("pll_mul", 32'(PLL_MUL_RESET), d);
   endtask : t_halt
   task automatic t_standby();
      wr(OFF_CTRL, 32'h0000_0309);
      wr(OFF_WAKE_SEL, 32'h0000_0020);
      wr(OFF_LP_ENTER, 32'h0000_0000);
      wait_for(hold, 1'b1, 4, n);
      ok("sb_clk", !(cpu_en | sys_en) & osc_en);
      gpio_a_n[6] <= 1'b0;
      repeat (40) @(posedge clk_sys);
      gpio_a_n <= 32'hFFFF_FFDF;
      repeat (2) @(posedge clk_sys);
      gpio_a_n <= 32'hFFFF_FFFF;
      repeat (30) @(posedge clk_sys);
      ok("sb_glitch", hold);
      gpio_a_n[5] <= 1'b0;
      wait_for(hold, 1'b0, 40, n);
      ok("sb_wake", !hold && n >= 4 * DIV);
      gpio_a_n[5] <= 1'b1;
      // watchdog interrupt with wake enabled ends standby, no reset
      wr(OFF_CTRL, 32'h0000_002A);
      wr(OFF_LP_ENTER, 32'h0000_0000);
      wait_for(wdi_n, 1'b0, 1200, n);
      wait_for(hold, 1'b0, 4, n);
      ok("sb_wd_wake", !hold && wake && wdr_n);
   endtask : t_standby
   // policy 0 resets at once, policy 1 after the nmi period
   task automatic t_loss(input logic pol);
      wr(OFF_CTRL, pol ? 32'h0000_0005 : 32'h0000_0001);
      wr(OFF_NMI_PERIOD, 32'h0000_0028);
      osc_run <= 1'b0;
      wait_for(limp, 1'b1, 200, n);
      ok("limp", limp);
      ok("nmi", nmi);
      wait_for(dev_n, 1'b0, 100, n);
      ok("rst_delay", pol ? n >= 40 : n <= 2);
      wait_for(dev_n, 1'b1, 40, n);
      rd(OFF_STATUS, d);
      ok("missing", d[ST_MISSING]);
      repeat (40) @(posedge clk_sys);
      rd(OFF_STATUS, e);
      chk("wd_frozen", {24'h00_0000, d[15:8]}, {24'h00_0000, e[15:8]});
      osc_run <= 1'b1;
      wr(OFF_STATUS, 32'h0000_0003);
      wait_for(limp, 1'b0, 50, n);
      ok("limp_off", !limp);
   endtask : t_loss
   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial begin
      repeat (4) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (3) @(posedge clk_sys);
      t_key();
      t_regs();
      t_idle();
      t_halt();
      t_standby();
      t_loss(1'b0);
      t_loss(1'b1);
      give_verdict();
   end
   // roughly five times the expected run length
   initial begin
      #500_000;
      bad_count++;
      give_verdict();
   end
endmodule : clock_fail_watchdog_lowpower_tb
